/* src/fpep_defines.svh */
// register offsets, field positions, reset values and timing counts for the flash sequencer
`ifndef FPEP_DEFINES_SVH
`define FPEP_DEFINES_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define FPEP_ADDR_OFS 12'h000
`define FPEP_DATA_OFS 12'h004
`define FPEP_CMD_OFS 12'h008
`define FPEP_STAT_OFS 12'h00C
`define FPEP_USEC_OFS 12'h010
`define FPEP_RIS_OFS 12'h014
`define FPEP_IMASK_OFS 12'h018
`define FPEP_MIS_OFS 12'h01C
`define FPEP_ICLR_OFS 12'h020
`define FPEP_PROT_OFS 12'h024
`define FPEP_RDATA_OFS 12'h028
`define FPEP_FETCH_OFS 12'h02C

// ************************************************************
// field positions
// ************************************************************
`define FPEP_CMD_ERASE 0
`define FPEP_CMD_PROG 1
`define FPEP_IRQ_DONE 0
`define FPEP_IRQ_ACCESS 1
`define FPEP_PROT_SEL_LSB 2
`define FPEP_STAT_BUSY 0

// ************************************************************
// reset values and timing
// ************************************************************
`define FPEP_USEC_RST 8'h32
`define FPEP_ERASE_US 16'h0010
`define FPEP_PROG_US 16'h0002
`define FPEP_ERASED_WORD 32'hFFFF_FFFF

`endif

/* src/fpep_pkg.sv */
// types shared by the flash sequencer files
package fpep_pkg;
	// protection setting per 2 kB pair
	typedef enum logic [1:0] {
		FPEP_RW = 2'b00,
		FPEP_RO = 2'b01,
		FPEP_XO = 2'b11
	} fpep_prot_t;
	// sequencer states
	typedef enum logic [3:0] {
		FPEP_IDLE = 4'b0001,
		FPEP_ERASE = 4'b0010,
		FPEP_PROG = 4'b0100,
		FPEP_DONE = 4'b1000
	} fpep_state_t;
endpackage

/* src/fpep_us_timer.sv */
// microsecond timer driven by a clocks-per-microsecond count
`include "fpep_defines.svh"
module fpep_us_timer (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// control
	input wire logic start,
	input wire logic [7:0] clkPerUs,
	input wire logic [15:0] durUs,
	// status
	output logic expired
);
	logic [7:0] tickCnt_r, tickCnt_nxt;
	logic [15:0] usCnt_r, usCnt_nxt;
	logic run_r, run_nxt;
	logic expired_r, expired_nxt;

	// count clocks to microseconds, then microseconds to the duration
	always_comb begin
		tickCnt_nxt = tickCnt_r;
		usCnt_nxt = usCnt_r;
		run_nxt = run_r;
		// expiry is held until the next start so a caller busy elsewhere cannot miss it
		expired_nxt = expired_r;
		if (start) begin
			tickCnt_nxt = 8'h01;
			usCnt_nxt = 16'h0000;
			run_nxt = 1'b1;
			expired_nxt = 1'b0;
		end else if (run_r) begin
			// a zero count is treated as one clock per microsecond
			if (tickCnt_r >= clkPerUs) begin
				tickCnt_nxt = 8'h01;
				usCnt_nxt = usCnt_r + 16'h0001;
				if (usCnt_r + 16'h0001 >= durUs) begin
					run_nxt = 1'b0;
					expired_nxt = 1'b1;
				end
			end else begin
				tickCnt_nxt = tickCnt_r + 8'h01;
			end
		end
	end

	// state registers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tickCnt_r <= 8'h00;
			usCnt_r <= 16'h0000;
			run_r <= 1'b0;
			expired_r <= 1'b0;
		end else begin
			tickCnt_r <= tickCnt_nxt;
			usCnt_r <= usCnt_nxt;
			run_r <= run_nxt;
			expired_r <= expired_nxt;
		end
	end

	assign expired = expired_r;
endmodule

/* src/fpep_prot_table.sv */
// per-pair protection table, tightening only
`include "fpep_defines.svh"
module fpep_prot_table #(
	parameter int PAIRS = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// committed settings reloaded at every reset
	input wire logic [2*PAIRS-1:0] committedProt,
	// software update
	input wire logic setEn,
	input wire logic [$clog2(PAIRS)-1:0] setSel,
	input wire logic [1:0] setVal,
	// lookup
	input wire logic [$clog2(PAIRS)-1:0] lookSel,
	output logic [1:0] lookVal,
	output logic [1:0] setCur
);
	logic [1:0] prot_r [PAIRS];
	logic [1:0] prot_nxt [PAIRS];
	logic loaded_r, loaded_nxt;
	localparam int SW = $clog2(PAIRS);

	// load committed values once after release, then only allow tightening
	genvar g;
	generate
		for (g = 0; g < PAIRS; g++) begin : gPair
			always_comb begin
				prot_nxt[g] = prot_r[g];
				if (!loaded_r) begin
					prot_nxt[g] = committedProt[2*g +: 2];
				end else if (setEn && setSel == SW'(g)) begin
					// new value must contain every bit already set
					if ((setVal & prot_r[g]) == prot_r[g] && setVal != 2'b10) begin
						prot_nxt[g] = setVal;
					end
				end
			end
			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					prot_r[g] <= 2'b00;
				end else begin
					prot_r[g] <= prot_nxt[g];
				end
			end
		end
	endgenerate

	// load marker
	always_comb loaded_nxt = 1'b1;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			loaded_r <= 1'b0;
		end else begin
			loaded_r <= loaded_nxt;
		end
	end

	assign lookVal = prot_r[lookSel];
	assign setCur = prot_r[setSel];
endmodule

/* src/fpep_flash_ctrl.sv */
// flash program/erase sequencer with block protection and APB registers
//
// The register addresses and register access over APB were chosen for this implementation.
`include "fpep_defines.svh"

// Summary of operation
// - flash split into independently erasable 1 kB blocks
// - erased block reads back all ones
// - one protection setting per 2 kB pair
// - read-only refuses erase and program, allows reads
// - execute-only serves instruction fetches only
// - program one word, storing AND with old
// - zero bits never return to one by programming
// - clocks-per-microsecond count times erase and program
// - forbidden access sets access violation flag
// - finished erase or program sets done flag
// - protection writes take effect immediately
// - clear request drops named pending flags
// - per-source mask gates the interrupt line
// - raw and masked status both readable
// - status has done and access bits
// - protection may only become more restrictive
// - uncommitted protection lost at reset
module fpep_flash_ctrl #(
	parameter int WORDS = 4096,
	parameter int BLK_WORDS = 256,
	parameter logic [63:0] COMMITTED_PROT = 64'h0000_0000_0000_0000
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// status
	output logic busy,
	output logic irq
);
	localparam int AW = $clog2(WORDS);
	localparam int BW = $clog2(BLK_WORDS);
	localparam int PAIRS = WORDS / (2 * BLK_WORDS);
	localparam int PW = $clog2(PAIRS);

	// ************************************************************
	// storage and registers
	// ************************************************************
	logic [31:0] mem [WORDS];
	logic [31:0] addr_r, addr_nxt;
	logic [31:0] data_r, data_nxt;
	logic [7:0] usec_r, usec_nxt;
	logic [1:0] ris_r, ris_nxt;
	logic [1:0] imask_r, imask_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic irq_r, irq_nxt;
	logic busy_r, busy_nxt;
	fpep_pkg::fpep_state_t state_r, state_nxt;
	logic [BW-1:0] eraseIdx_r, eraseIdx_nxt;
	logic timerStart;
	logic [15:0] timerDur;
	logic timerDone;
	logic memWe;
	logic [AW-1:0] memAddr;
	logic [31:0] memWdata;
	logic [1:0] lookProt;
	logic protSetEn;
	logic accessErr;
	logic opDone;
	logic apbAccess;
	logic [AW-1:0] wordIdx;

	assign apbAccess = psel && penable && !pready_r;
	assign wordIdx = addr_r[AW+1:2];

	// ************************************************************
	// helpers
	// ************************************************************
	fpep_us_timer uTimer (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.start(timerStart),
		.clkPerUs(usec_r),
		.durUs(timerDur),
		.expired(timerDone)
	);

	// lookup always uses the pair holding the address register
	fpep_prot_table #(.PAIRS(PAIRS)) uProt (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.committedProt(COMMITTED_PROT[2*PAIRS-1:0]),
		.setEn(protSetEn),
		.setSel(pwdata[`FPEP_PROT_SEL_LSB +: PW]),
		.setVal(pwdata[1:0]),
		.lookSel(wordIdx[AW-1 -: PW]),
		.lookVal(lookProt),
		.setCur()
	);

	assign protSetEn = apbAccess && pwrite && paddr == `FPEP_PROT_OFS;

	// ************************************************************
	// sequencer
	// ************************************************************
	// one word per erase step keeps the array a plain memory
	always_comb begin
		state_nxt = state_r;
		eraseIdx_nxt = eraseIdx_r;
		busy_nxt = busy_r;
		timerStart = 1'b0;
		timerDur = `FPEP_PROG_US;
		memWe = 1'b0;
		memAddr = wordIdx;
		memWdata = data_r;
		opDone = 1'b0;
		accessErr = 1'b0;
		case (state_r)
			fpep_pkg::FPEP_IDLE: begin
				if (apbAccess && pwrite && paddr == `FPEP_CMD_OFS) begin
					if ((pwdata[`FPEP_CMD_ERASE] || pwdata[`FPEP_CMD_PROG]) && lookProt != fpep_pkg::FPEP_RW) begin
						accessErr = 1'b1;
					end else if (pwdata[`FPEP_CMD_ERASE]) begin
						state_nxt = fpep_pkg::FPEP_ERASE;
						eraseIdx_nxt = '0;
						busy_nxt = 1'b1;
						timerStart = 1'b1;
						timerDur = `FPEP_ERASE_US;
					end else if (pwdata[`FPEP_CMD_PROG]) begin
						state_nxt = fpep_pkg::FPEP_PROG;
						busy_nxt = 1'b1;
						timerStart = 1'b1;
					end
				end
			end
			fpep_pkg::FPEP_ERASE: begin
				// whole 1 kB block filled with ones, others untouched
				memWe = 1'b1;
				memAddr = {wordIdx[AW-1:BW], eraseIdx_r};
				memWdata = `FPEP_ERASED_WORD;
				if (eraseIdx_r != BW'(BLK_WORDS - 1)) begin
					eraseIdx_nxt = eraseIdx_r + BW'(1);
				end else begin
					memWe = 1'b0;
					if (timerDone) begin
						memWe = 1'b1;
						state_nxt = fpep_pkg::FPEP_DONE;
					end
				end
			end
			fpep_pkg::FPEP_PROG: begin
				if (timerDone) begin
					memWe = 1'b1;
					memWdata = mem[wordIdx] & data_r;
					state_nxt = fpep_pkg::FPEP_DONE;
				end
			end
			fpep_pkg::FPEP_DONE: begin
				opDone = 1'b1;
				busy_nxt = 1'b0;
				state_nxt = fpep_pkg::FPEP_IDLE;
			end
			default: begin
				state_nxt = fpep_pkg::FPEP_IDLE;
				busy_nxt = 1'b0;
			end
		endcase
		// data reads of execute-only flash are forbidden too
		if (apbAccess && !pwrite && paddr == `FPEP_RDATA_OFS && lookProt == fpep_pkg::FPEP_XO) begin
			accessErr = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= fpep_pkg::FPEP_IDLE;
			eraseIdx_r <= '0;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			eraseIdx_r <= eraseIdx_nxt;
			busy_r <= busy_nxt;
		end
	end

	// array has no reset; contents are the flash itself
	always_ff @(posedge ref_clk) begin
		if (memWe) begin
			mem[memAddr] <= memWdata;
		end
	end

	// ************************************************************
	// register file
	// ************************************************************
	always_comb begin
		addr_nxt = addr_r;
		data_nxt = data_r;
		usec_nxt = usec_r;
		imask_nxt = imask_r;
		ris_nxt = ris_r;
		prdata_nxt = prdata_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		// clear first so a same-cycle event still wins
		if (apbAccess && pwrite && paddr == `FPEP_ICLR_OFS) begin
			ris_nxt = ris_r & ~pwdata[1:0];
		end
		if (opDone) begin
			ris_nxt[`FPEP_IRQ_DONE] = 1'b1;
		end
		if (accessErr) begin
			ris_nxt[`FPEP_IRQ_ACCESS] = 1'b1;
		end
		if (apbAccess) begin
			pready_nxt = 1'b1;
			prdata_nxt = 32'h0000_0000;
			if (pwrite) begin
				case (paddr)
					// address and data held while busy so the operation stays stable
					`FPEP_ADDR_OFS: if (!busy_r) addr_nxt = {pwdata[31:2], 2'b00};
					`FPEP_DATA_OFS: if (!busy_r) data_nxt = pwdata;
					`FPEP_USEC_OFS: usec_nxt = pwdata[7:0];
					`FPEP_IMASK_OFS: imask_nxt = pwdata[1:0];
					`FPEP_CMD_OFS, `FPEP_ICLR_OFS, `FPEP_PROT_OFS: ;
					default: pslverr_nxt = 1'b1;
				endcase
			end else begin
				case (paddr)
					`FPEP_ADDR_OFS: prdata_nxt = addr_r;
					`FPEP_DATA_OFS: prdata_nxt = data_r;
					`FPEP_STAT_OFS: prdata_nxt = {31'h0000_0000, busy_r};
					`FPEP_USEC_OFS: prdata_nxt = {24'h00_0000, usec_r};
					`FPEP_RIS_OFS: prdata_nxt = {30'h0000_0000, ris_r};
					`FPEP_IMASK_OFS: prdata_nxt = {30'h0000_0000, imask_r};
					`FPEP_MIS_OFS: prdata_nxt = {30'h0000_0000, ris_r & imask_r};
					`FPEP_PROT_OFS: prdata_nxt = {30'h0000_0000, lookProt};
					// data read: refused for execute-only pairs
					`FPEP_RDATA_OFS: begin
						if (lookProt == fpep_pkg::FPEP_XO) begin
							pslverr_nxt = 1'b1;
						end else begin
							prdata_nxt = mem[wordIdx];
						end
					end
					// instruction fetch: always served
					`FPEP_FETCH_OFS: prdata_nxt = mem[wordIdx];
					default: pslverr_nxt = 1'b1;
				endcase
			end
		end
		irq_nxt = |(ris_nxt & imask_nxt);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_r <= 32'h0000_0000;
			data_r <= 32'hFFFF_FFFF;
			usec_r <= `FPEP_USEC_RST;
			imask_r <= 2'b00;
			ris_r <= 2'b00;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			addr_r <= addr_nxt;
			data_r <= data_nxt;
			usec_r <= usec_nxt;
			imask_r <= imask_nxt;
			ris_r <= ris_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			irq_r <= irq_nxt;
		end
	end

	// outputs straight from flip-flops
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign busy = busy_r;
	assign irq = irq_r;
endmodule

/* bench/fpep_flash_ctrl_assertions.sv */
// concurrent checks on the flash sequencer ports
`include "fpep_defines.svh"
module fpep_flash_ctrl_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// status
	input wire logic busy,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// ********
	// bus answer
	// ********
	a_ready_time: assert property (psel && penable && !pready |=> pready) else $error("no answer in one cycle");
	a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("answer without access");
	a_ready_pulse: assert property (pready |=> !pready) else $error("answer held too long");
	a_err_cause: assert property (pslverr |-> pready && ((!pwrite && paddr == `FPEP_RDATA_OFS)
		|| paddr > `FPEP_FETCH_OFS || paddr[1:0] != 2'b00)) else $error("error on legal access");
	a_err_zero: assert property (pslverr && paddr == `FPEP_RDATA_OFS |-> prdata == 32'h0000_0000)
		else $error("refused read leaked data");
	// ********
	// operation timing
	// ********
	a_busy_cause: assert property ($rose(busy) |-> pready && pwrite && paddr == `FPEP_CMD_OFS)
		else $error("busy without command");
	a_busy_min: assert property ($rose(busy) |-> busy [*3]) else $error("operation too short");
	a_busy_ends: assert property ($rose(busy) |-> ##[3:1000] !busy) else $error("operation never ends");
	// irq only follows a register access or the end of an operation
	a_irq_cause: assert property ($rose(irq) |-> pready || $past(busy))
		else $error("irq without cause");
	c_op: cover property ($fell(busy));
	c_err: cover property (pslverr);
	c_irq: cover property ($rose(irq));
endmodule
bind fpep_flash_ctrl fpep_flash_ctrl_chk i_chk (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .busy(busy), .irq(irq));

/* bench/fpep_apb_host.sv */
// processor side apb requester for the flash sequencer
module fpep_apb_host (
	// clock
	input wire logic ref_clk,
	// request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	// answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end
	// one transfer; callers give aligned whole words only
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e, output logic hung);
		hung = 1'b1;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (int n = 0; n < 20; n++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) begin
				r = prdata;
				e = pslverr;
				hung = 1'b0;
				break;
			end
		end
		// released lines show the inverse so stale values never pass
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

/* bench/flash_program_erase_protect_test.sv */
// self-checking bench for the flash sequencer
`include "fpep_defines.svh"
module flash_program_erase_protect_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} fpep_row_t;
	logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, busy, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	int errCount = 0;
	int nChecks = 0;
	// reads, writes and one unmapped place
	fpep_row_t rows[8] = '{'{0, `FPEP_USEC_OFS, 0, 32'h0000_0032, 0}, '{0, `FPEP_RIS_OFS, 0, 0, 0},
		'{0, `FPEP_IMASK_OFS, 0, 0, 0}, '{1, `FPEP_USEC_OFS, 4, 0, 0}, '{0, `FPEP_USEC_OFS, 0, 4, 0},
		'{1, `FPEP_IMASK_OFS, 3, 0, 0}, '{0, `FPEP_MIS_OFS, 0, 0, 0}, '{0, 12'h030, 0, 0, 1}};
	fpep_flash_ctrl i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .busy(busy), .irq(irq));
	fpep_apb_host i_host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	// 50 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ********
	// tasks
	// ********
	task automatic wrapUp();
		if (errCount == 0 && nChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		nChecks++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	// transfer, then compare error flag and read data
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x, input logic e);
		logic [31:0] r;
		logic re, h;
		i_host.xfer(w, a, d, r, re, h);
		if (h) begin
			errCount++;
			wrapUp();
		end
		chk("pslverr", {31'd0, e}, {31'd0, re});
		if (!w && !e) chk($sformatf("rd %h", a), x, r);
	endtask
	task automatic rdw(input logic [11:0] a, input logic [31:0] x);
		bus(1, `FPEP_ADDR_OFS, {20'd0, a}, 0, 0);
		bus(0, `FPEP_RDATA_OFS, 0, x, 0);
	endtask
	// start an operation and poll status until it is idle again
	task automatic op(input logic [11:0] a, input logic [31:0] d, input logic [31:0] c, input logic b);
		logic [31:0] r;
		logic re, h;
		bus(1, `FPEP_ADDR_OFS, {20'd0, a}, 0, 0);
		bus(1, `FPEP_DATA_OFS, d, 0, 0);
		bus(1, `FPEP_CMD_OFS, c, 0, 0);
		chk("busy", {31'd0, b}, {31'd0, busy});
		// an address write while busy must not move the running operation
		if (b) begin
			bus(1, `FPEP_ADDR_OFS, 32'h0000_0FFC, 0, 0);
			bus(0, `FPEP_ADDR_OFS, 0, {20'd0, a}, 0);
		end
		for (int n = 0; n < 100; n++) begin
			i_host.xfer(1'b0, `FPEP_STAT_OFS, 0, r, re, h);
			if (r[0] === 1'b0) begin
				chk("busy", 0, {31'd0, busy});
				return;
			end
		end
		errCount++;
		wrapUp();
	endtask
	// ********
	// main sequence
	// ********
	initial begin
		arst_n = 1'b0;
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		foreach (rows[i]) bus(rows[i].w, rows[i].a, rows[i].d, rows[i].x, rows[i].e);
		op(12'h000, 0, 1, 1);
		rdw(12'h3FC, `FPEP_ERASED_WORD);
		bus(0, `FPEP_RIS_OFS, 0, 1, 0);
		chk("irq", 1, {31'd0, irq});
		op(12'h004, 32'hF0F0_1234, 2, 1);
		rdw(12'h004, 32'hF0F0_1234);
		op(12'h004, 32'h0F0F_FF00, 2, 1);
		rdw(12'h004, 32'h0000_1200);
		op(12'h400, 0, 1, 1);
		rdw(12'h004, 32'h0000_1200);
		bus(1, `FPEP_ICLR_OFS, 1, 0, 0);
		bus(0, `FPEP_RIS_OFS, 0, 0, 0);
		chk("irq", 0, {31'd0, irq});
		bus(1, `FPEP_IMASK_OFS, 2, 0, 0);
		op(12'h800, 0, 1, 1);
		bus(0, `FPEP_RIS_OFS, 0, 1, 0);
		bus(0, `FPEP_MIS_OFS, 0, 0, 0);
		chk("irq", 0, {31'd0, irq});
		bus(1, `FPEP_PROT_OFS, 5, 0, 0);
		bus(0, `FPEP_PROT_OFS, 0, 1, 0);
		op(12'h800, 0, 2, 0);
		rdw(12'h800, `FPEP_ERASED_WORD);
		bus(0, `FPEP_MIS_OFS, 0, 2, 0);
		chk("irq", 1, {31'd0, irq});
		bus(1, `FPEP_PROT_OFS, 4, 0, 0);
		bus(0, `FPEP_PROT_OFS, 0, 1, 0);
		bus(1, `FPEP_PROT_OFS, 7, 0, 0);
		bus(0, `FPEP_PROT_OFS, 0, 3, 0);
		bus(0, `FPEP_RDATA_OFS, 0, 0, 1);
		bus(0, `FPEP_FETCH_OFS, 0, `FPEP_ERASED_WORD, 0);
		bus(1, `FPEP_ADDR_OFS, 32'h0000_0C00, 0, 0);
		bus(0, `FPEP_PROT_OFS, 0, 3, 0);
		bus(1, `FPEP_ADDR_OFS, 32'h0000_0400, 0, 0);
		bus(0, `FPEP_PROT_OFS, 0, 0, 0);
		// second reset drops uncommitted protection
		arst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		bus(1, `FPEP_ADDR_OFS, 32'h0000_0800, 0, 0);
		bus(0, `FPEP_PROT_OFS, 0, 0, 0);
		bus(0, `FPEP_USEC_OFS, 0, 32'h0000_0032, 0);
		wrapUp();
	end
endmodule
